//--- verilog/uurb_pkg.sv
package uurb_pkg;

  // Vendor control request setup fields
  typedef struct packed {
    logic [7:0] req_type;
    logic [7:0] code;
    logic [15:0] value;
    logic [15:0] index;
  } uurb_req_t;

  // Line fault events of one channel, in status bit order 7 down to 3
  typedef struct packed {
    logic brk_now;
    logic overrun;
    logic parity;
    logic framing;
    logic brk_err;
  } uurb_fault_t;

  // Settings handed to the serial engine of one channel
  typedef struct packed {
    logic half_duplex;
    logic [2:0] flow_mode;
    logic rx_en;
    logic tx_en;
    logic [7:0] resume_char;
    logic [7:0] pause_char;
    logic [3:0] xcvr_delay;
    logic [15:0] brk_len;
    logic [9:0] pin_dir;
  } uurb_cfg_t;

  typedef enum logic [2:0] {
    FLOW_NONE = 3'h0,
    FLOW_HW = 3'h1,
    FLOW_SW = 3'h2,
    FLOW_MD_RX = 3'h3,
    FLOW_MD_BOTH = 3'h4
  } uurb_flow_t;

  // Request decode
  localparam logic [7:0] RT_VENDOR_DEV_OUT = 8'h40;
  localparam logic [7:0] RT_VENDOR_IF_OUT = 8'h41;
  localparam logic [7:0] RT_VENDOR_DEV_IN = 8'hc0;
  localparam logic [7:0] RT_VENDOR_IF_IN = 8'hc1;
  localparam logic [7:0] REQ_CODE_REG = 8'h00;
  localparam logic [7:0] CHAN_A = 8'h00;
  localparam logic [7:0] CHAN_B = 8'h02;
  localparam logic [15:0] IDX_VERSION = 16'h0260;
  localparam logic [15:0] IDX_LINK_STAT = 16'h0262;
  localparam logic [15:0] LINK_STAT_MASK = 16'h3f3f;

  // Stored read/write registers: address and writable bits
  localparam int N_RW = 26;
  localparam logic [7:0] RW_ADDR [N_RW] = '{
    8'h00, 8'h06, 8'h07, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h11, 8'h12,
    8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1f, 8'h40, 8'h42, 8'h43,
    8'h45, 8'h46, 8'h47, 8'h60, 8'h6a, 8'h6b};
  localparam logic [15:0] RW_MASK [N_RW] = '{
    16'h0003, 16'h000f, 16'h00ff, 16'h00ff, 16'hffff, 16'h000f, 16'h03ff,
    16'h03ff, 16'h07ff, 16'h0003, 16'h0bff, 16'h07ff, 16'h07ff, 16'h0007,
    16'h0007, 16'hffff, 16'h000c, 16'h0007, 16'h0001, 16'h0007, 16'h0001,
    16'h0001, 16'h03ff, 16'h0001, 16'h3ccf, 16'hbccf};
  localparam int SLOT_ENABLE = 0;
  localparam int SLOT_FLOW = 1;
  localparam int SLOT_RESUME = 2;
  localparam int SLOT_PAUSE = 3;
  localparam int SLOT_BREAK = 4;
  localparam int SLOT_DELAY = 5;
  localparam int SLOT_DIR = 7;
  localparam int SLOT_TX_PURGE = 17;
  localparam int SLOT_RX_PURGE = 19;
  localparam logic [15:0] RST_RESUME = 16'h0011;
  localparam logic [15:0] RST_PAUSE = 16'h0013;

  // Registers with side effects or no storage
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_FAULT = 8'h09;
  localparam logic [7:0] ADDR_BREAK = 8'h0a;
  localparam logic [7:0] ADDR_DRIVE_HIGH = 8'h0e;
  localparam logic [7:0] ADDR_DRIVE_LOW = 8'h0f;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h10;
  localparam logic [7:0] ADDR_TX_PURGE = 8'h40;
  localparam logic [7:0] ADDR_TX_LEVEL = 8'h41;
  localparam logic [7:0] ADDR_RX_PURGE = 8'h43;
  localparam logic [7:0] ADDR_RX_LEVEL = 8'h44;
  localparam logic [15:0] PIN_MASK = 16'h03ff;
  localparam int FAULT_LSB = 3;

endpackage

//--- verilog/uurb_fault_latch.sv
module uurb_fault_latch (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [4:0] ev_i,
  input wire logic clr_i,
  output logic [4:0] flags_o
);

  logic [4:0] flags_reg;
  logic [4:0] flags_next;

  // Sticky history; a new event beats the clear of a read
  always_comb
  begin
    flags_next = (flags_reg & {5{~clr_i}}) | ev_i; // R11
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      flags_reg <= '0;
    else
      flags_reg <= flags_next;
  end

  assign flags_o = flags_reg;

  property p_set_wins;
    @(posedge clk_sys_i) disable iff (reset_i)
      (|ev_i) |=> ((flags_reg & $past(ev_i)) == $past(ev_i));
  endproperty
  a_set_wins: assert property (p_set_wins) // R11
    else $error("fault event lost");

endmodule // uurb_fault_latch

//--- verilog/uurb_register_bank.sv
// How it works
// R1: Host reaches registers through vendor write/read requests
// R2: Version and link status use own requests
// R3: Host disables channel before writing registers
// R4: Host re-enables channel; pin, break, fault exempt
// R5: Every register is a 16-bit location
// R6: Upper and zero-marked bits are reserved
// R7: Host writes zeros into reserved bits
// R8: Enable bit 1 receiver, bit 0 transmitter
// R9: Three-bit flow mode selects handshake scheme
// R10: Resume 0x11, pause 0x13 gate transmitter
// R11: Fault flags accumulate, reading clears them
// R12: Unmapped reads give zero, writes ignored
module uurb_register_bank #(
  // Arbitrary value
  parameter logic [15:0] VERSION_CODE = 16'h0001
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire uurb_pkg::uurb_req_t req_i,
  output logic rsp_valid_o,
  output logic [15:0] rsp_data_o,
  output logic rsp_stall_o,
  input wire uurb_pkg::uurb_fault_t [1:0] fault_i,
  input wire logic [1:0] rx_char_valid_i,
  input wire logic [1:0][7:0] rx_char_i,
  input wire logic [1:0][11:0] pin_level_i,
  input wire logic [1:0][9:0] tx_count_i,
  input wire logic [1:0][9:0] rx_count_i,
  output uurb_pkg::uurb_cfg_t [1:0] cfg_o,
  output logic [1:0][9:0] pin_out_o,
  output logic [1:0] tx_paused_o,
  output logic [1:0] tx_purge_o,
  output logic [1:0] rx_purge_o,
  output logic [1:0] brk_load_o
);

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  logic [15:0] rw_reg [2][uurb_pkg::N_RW];
  logic [9:0] pin_out_reg [2];
  logic [1:0] paused_reg;
  logic [1:0] tx_purge_reg;
  logic [1:0] rx_purge_reg;
  logic [1:0] brk_load_reg;
  logic [4:0] fault_flags [2];
  logic [1:0] fault_clr;
  logic [15:0] link_stat_reg;
  logic rsp_valid_reg;
  logic [15:0] rsp_data_reg;
  logic rsp_stall_reg;

  logic gen_wr;
  logic gen_rd;
  logic ver_rd;
  logic stat_rd;
  logic stat_wr;
  logic chan_ok;
  logic ch;
  logic [7:0] addr;
  logic hit;
  logic [4:0] slot;
  logic [15:0] mask;
  logic wr_ok;
  logic rd_ok;
  logic [15:0] rd_data;

  // Request decode
  always_comb
  begin
    addr = req_i.index[7:0];
    chan_ok = (req_i.index[15:8] == uurb_pkg::CHAN_A) ||
              (req_i.index[15:8] == uurb_pkg::CHAN_B);
    ch = (req_i.index[15:8] == uurb_pkg::CHAN_B);
    gen_wr = req_valid_i && req_i.code == uurb_pkg::REQ_CODE_REG &&
             req_i.req_type == uurb_pkg::RT_VENDOR_IF_OUT; // R1
    gen_rd = req_valid_i && req_i.code == uurb_pkg::REQ_CODE_REG &&
             req_i.req_type == uurb_pkg::RT_VENDOR_IF_IN; // R1
    ver_rd = req_valid_i && req_i.code == uurb_pkg::REQ_CODE_REG &&
             req_i.req_type == uurb_pkg::RT_VENDOR_DEV_IN &&
             req_i.index == uurb_pkg::IDX_VERSION; // R2
    stat_rd = req_valid_i && req_i.code == uurb_pkg::REQ_CODE_REG &&
              req_i.req_type == uurb_pkg::RT_VENDOR_DEV_IN &&
              req_i.index == uurb_pkg::IDX_LINK_STAT; // R2
    stat_wr = req_valid_i && req_i.code == uurb_pkg::REQ_CODE_REG &&
              req_i.req_type == uurb_pkg::RT_VENDOR_DEV_OUT &&
              req_i.index == uurb_pkg::IDX_LINK_STAT; // R2
    wr_ok = gen_wr && chan_ok;
    rd_ok = gen_rd && chan_ok;
  end

  // Stored register lookup with writable bit mask
  always_comb
  begin
    hit = 1'b0;
    slot = '0;
    mask = '0;
    for (int i = 0; i < uurb_pkg::N_RW; i++)
    begin
      if (addr == uurb_pkg::RW_ADDR[i])
      begin
        hit = 1'b1;
        slot = 5'(i);
        mask = uurb_pkg::RW_MASK[i]; // R6
      end
    end
  end

  // Read data; undefined addresses read zero
  always_comb
  begin
    rd_data = '0; // R12
    if (hit)
      rd_data = rw_reg[ch][slot];
    else
    begin
      unique case (addr)
        uurb_pkg::ADDR_FAULT:
          rd_data = 16'({fault_flags[ch], 3'h0}); // R11
        uurb_pkg::ADDR_PIN_LEVEL:
          rd_data = 16'(pin_level_i[ch]);
        uurb_pkg::ADDR_TX_LEVEL:
          rd_data = 16'(tx_count_i[ch]);
        uurb_pkg::ADDR_RX_LEVEL:
          rd_data = 16'(rx_count_i[ch]);
        default:
          rd_data = '0; // R12
      endcase
    end
  end

  // Answer to each request, one cycle after it is taken
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= '0;
      rsp_stall_reg <= 1'b0;
    end
    else
    begin
      rsp_valid_reg <= wr_ok || rd_ok || ver_rd || stat_rd || stat_wr; // R5
      rsp_stall_reg <= req_valid_i &&
                       !(wr_ok || rd_ok || ver_rd || stat_rd || stat_wr);
      if (rd_ok)
        rsp_data_reg <= rd_data; // R5
      else if (ver_rd)
        rsp_data_reg <= VERSION_CODE; // R2
      else if (stat_rd)
        rsp_data_reg <= link_stat_reg; // R2
      else
        rsp_data_reg <= '0;
    end
  end

  // Link status, only through its own request
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      link_stat_reg <= '0;
    else if (stat_wr)
      link_stat_reg <= req_i.value & uurb_pkg::LINK_STAT_MASK; // R2
  end

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    logic sel;
    logic pause_hit;
    logic resume_hit;

    assign sel = ch == 1'(c);
    assign fault_clr[c] = rd_ok && sel && addr == uurb_pkg::ADDR_FAULT; // R11
    assign pause_hit = rx_char_valid_i[c] &&
                       rx_char_i[c] == rw_reg[c][uurb_pkg::SLOT_PAUSE][7:0];
    assign resume_hit = rx_char_valid_i[c] &&
                        rx_char_i[c] == rw_reg[c][uurb_pkg::SLOT_RESUME][7:0];

    // Stored registers; reserved bits are dropped on write
    always_ff @(posedge clk_sys_i)
    begin
      if (reset_i)
      begin
        for (int i = 0; i < uurb_pkg::N_RW; i++)
          rw_reg[c][i] <= '0; // R8
        rw_reg[c][uurb_pkg::SLOT_RESUME] <= uurb_pkg::RST_RESUME; // R10
        rw_reg[c][uurb_pkg::SLOT_PAUSE] <= uurb_pkg::RST_PAUSE; // R10
      end
      else if (wr_ok && sel && hit)
        rw_reg[c][slot] <= req_i.value & mask; // R6
    end

    // Pin drive latch, set and clear by write
    always_ff @(posedge clk_sys_i)
    begin
      if (reset_i)
        pin_out_reg[c] <= '0;
      else if (wr_ok && sel && addr == uurb_pkg::ADDR_DRIVE_HIGH)
        pin_out_reg[c] <= pin_out_reg[c] | req_i.value[9:0];
      else if (wr_ok && sel && addr == uurb_pkg::ADDR_DRIVE_LOW)
        pin_out_reg[c] <= pin_out_reg[c] & ~req_i.value[9:0];
    end

    // Software flow control pause state
    always_ff @(posedge clk_sys_i)
    begin
      if (reset_i)
        paused_reg[c] <= 1'b0;
      else if (rw_reg[c][uurb_pkg::SLOT_FLOW][2:0] != uurb_pkg::FLOW_SW) // R9
        paused_reg[c] <= 1'b0;
      else if (pause_hit)
        paused_reg[c] <= 1'b1; // R10
      else if (resume_hit)
        paused_reg[c] <= 1'b0; // R10
    end

    // One-cycle strobes for write side effects
    always_ff @(posedge clk_sys_i)
    begin
      if (reset_i)
      begin
        tx_purge_reg[c] <= 1'b0;
        rx_purge_reg[c] <= 1'b0;
        brk_load_reg[c] <= 1'b0;
      end
      else
      begin
        tx_purge_reg[c] <= wr_ok && sel && addr == uurb_pkg::ADDR_TX_PURGE &&
                           req_i.value[0];
        rx_purge_reg[c] <= wr_ok && sel && addr == uurb_pkg::ADDR_RX_PURGE &&
                           req_i.value[0];
        brk_load_reg[c] <= wr_ok && sel && addr == uurb_pkg::ADDR_BREAK;
      end
    end

    uurb_fault_latch u_fault (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .ev_i(fault_i[c]),
      .clr_i(fault_clr[c]),
      .flags_o(fault_flags[c])
    );

    always_comb
    begin
      cfg_o[c].half_duplex = rw_reg[c][uurb_pkg::SLOT_FLOW][3];
      cfg_o[c].flow_mode = rw_reg[c][uurb_pkg::SLOT_FLOW][2:0]; // R9
      cfg_o[c].rx_en = rw_reg[c][uurb_pkg::SLOT_ENABLE][1]; // R8
      cfg_o[c].tx_en = rw_reg[c][uurb_pkg::SLOT_ENABLE][0]; // R8
      cfg_o[c].resume_char = rw_reg[c][uurb_pkg::SLOT_RESUME][7:0];
      cfg_o[c].pause_char = rw_reg[c][uurb_pkg::SLOT_PAUSE][7:0];
      cfg_o[c].xcvr_delay = rw_reg[c][uurb_pkg::SLOT_DELAY][3:0];
      cfg_o[c].brk_len = rw_reg[c][uurb_pkg::SLOT_BREAK];
      cfg_o[c].pin_dir = rw_reg[c][uurb_pkg::SLOT_DIR][9:0];
      pin_out_o[c] = pin_out_reg[c];
    end
  end

  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_data_o = rsp_data_reg;
  assign rsp_stall_o = rsp_stall_reg;
  assign tx_paused_o = paused_reg;
  assign tx_purge_o = tx_purge_reg;
  assign rx_purge_o = rx_purge_reg;
  assign brk_load_o = brk_load_reg;

  property p_read_answers;
    rd_ok |=> rsp_valid_o && !rsp_stall_o;
  endproperty
  a_read_answers: assert property (p_read_answers) // R1
    else $error("register read not answered");

  property p_general_keeps_stat;
    (gen_wr || gen_rd) |=> $stable(link_stat_reg) && !$past(ver_rd);
  endproperty
  a_general_keeps_stat: assert property (p_general_keeps_stat) // R2
    else $error("general request touched link status");

  property p_version_read;
    ver_rd |=> rsp_valid_o && rsp_data_o == VERSION_CODE;
  endproperty
  a_version_read: assert property (p_version_read) // R2
    else $error("version read wrong");

  property p_reserved_zero;
    rw_reg[0][uurb_pkg::SLOT_ENABLE][15:2] == '0 &&
    rw_reg[1][uurb_pkg::SLOT_FLOW][15:4] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // R6
    else $error("reserved bit stored");

  property p_enable_write;
    (wr_ok && !ch && addr == uurb_pkg::ADDR_ENABLE) |=>
      cfg_o[0].rx_en == $past(req_i.value[1]) && cfg_o[0].tx_en == $past(req_i.value[0]);
  endproperty
  a_enable_write: assert property (p_enable_write) // R8
    else $error("enable bits not taken");

  property p_flow_gate;
    (cfg_o[0].flow_mode != uurb_pkg::FLOW_SW) |=> !tx_paused_o[0];
  endproperty
  a_flow_gate: assert property (p_flow_gate) // R9
    else $error("paused outside software flow mode");

  property p_pause_char;
    (rx_char_valid_i[0] && cfg_o[0].flow_mode == uurb_pkg::FLOW_SW &&
     rx_char_i[0] == cfg_o[0].pause_char) |=> tx_paused_o[0];
  endproperty
  a_pause_char: assert property (p_pause_char) // R10
    else $error("pause character ignored");

  property p_reset_chars;
    $past(reset_i) |-> cfg_o[1].resume_char == 8'h11 && cfg_o[1].pause_char == 8'h13;
  endproperty
  a_reset_chars: assert property (p_reset_chars) // R10
    else $error("flow characters wrong after reset");

  property p_fault_clear;
    (fault_clr[0] && fault_i[0] == '0) |=> fault_flags[0] == '0;
  endproperty
  a_fault_clear: assert property (p_fault_clear) // R11
    else $error("fault flags not cleared by read");

  property p_unmapped_zero;
    (rd_ok && !hit && addr != uurb_pkg::ADDR_FAULT && addr != uurb_pkg::ADDR_PIN_LEVEL &&
     addr != uurb_pkg::ADDR_TX_LEVEL && addr != uurb_pkg::ADDR_RX_LEVEL)
      |=> rsp_valid_o && rsp_data_o == '0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) // R12
    else $error("unmapped read not zero");

endmodule // uurb_register_bank

//--- tb/uurb_host_model.sv
module uurb_host_model (
  input wire logic clk_sys_i,
  output logic req_valid_o,
  output uurb_pkg::uurb_req_t req_o,
  input wire logic rsp_valid_i,
  input wire logic [15:0] rsp_data_i,
  input wire logic rsp_stall_i
);
  timeunit 1ns;
  timeprecision 1ns;

  logic rsp_ok;
  logic rsp_stall_seen;

  initial
  begin
    req_valid_o = 1'b0;
    req_o = '0;
    rsp_ok = 1'b0;
    rsp_stall_seen = 1'b0;
  end

  // One control request; setup fields held until the taking edge, answer one cycle later
  task automatic xfer(input logic [7:0] rtype, input logic [15:0] idx, input logic [15:0] val,
                      input logic [7:0] rcode, output logic [15:0] data);
    @(posedge clk_sys_i);
    #1;
    req_valid_o = 1'b1;
    req_o = '{req_type: rtype, code: rcode, value: val, index: idx};
    @(posedge clk_sys_i);
    #1;
    data = rsp_data_i;
    rsp_ok = rsp_valid_i;
    rsp_stall_seen = rsp_stall_i;
    req_valid_o = 1'b0;
    req_o = ~req_o;
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] ch, input logic [7:0] addr, input logic [15:0] val);
    logic [15:0] d;
    xfer(uurb_pkg::RT_VENDOR_IF_OUT, {ch, addr}, val, uurb_pkg::REQ_CODE_REG, d);
  endtask

  task automatic rd(input logic [7:0] ch, input logic [7:0] addr, output logic [15:0] data);
    xfer(uurb_pkg::RT_VENDOR_IF_IN, {ch, addr}, 16'h0000, uurb_pkg::REQ_CODE_REG, data);
  endtask

  // Setting change wrapped in channel off and back on
  task automatic cfg_write(input logic [7:0] ch, input logic [7:0] addr, input logic [15:0] val,
                           input logic [15:0] en);
    wr(ch, uurb_pkg::ADDR_ENABLE, 16'h0000);
    wr(ch, addr, val);
    wr(ch, uurb_pkg::ADDR_ENABLE, en);
  endtask
endmodule // uurb_host_model

//--- tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys_i;
  logic reset_i;
  logic req_valid_i;
  uurb_pkg::uurb_req_t req_i;
  logic rsp_valid_o;
  logic [15:0] rsp_data_o;
  logic rsp_stall_o;
  uurb_pkg::uurb_fault_t [1:0] fault_i;
  logic [1:0] rx_char_valid_i;
  logic [1:0][7:0] rx_char_i;
  logic [1:0][11:0] pin_level_i;
  logic [1:0][9:0] tx_count_i;
  logic [1:0][9:0] rx_count_i;
  uurb_pkg::uurb_cfg_t [1:0] cfg_o;
  logic [1:0][9:0] pin_out_o;
  logic [1:0] tx_paused_o;
  logic [1:0] tx_purge_o;
  logic [1:0] rx_purge_o;
  logic [1:0] brk_load_o;
  int failures;
  int n_tests;
  int cycles;
  int n_pulse [3];
  logic [15:0] d;

  uurb_register_bank dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_stall_o(rsp_stall_o),
    .fault_i(fault_i), .rx_char_valid_i(rx_char_valid_i), .rx_char_i(rx_char_i),
    .pin_level_i(pin_level_i), .tx_count_i(tx_count_i), .rx_count_i(rx_count_i), .cfg_o(cfg_o),
    .pin_out_o(pin_out_o), .tx_paused_o(tx_paused_o), .tx_purge_o(tx_purge_o),
    .rx_purge_o(rx_purge_o), .brk_load_o(brk_load_o));

  uurb_host_model host (.clk_sys_i(clk_sys_i), .req_valid_o(req_valid_i), .req_o(req_i),
    .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o), .rsp_stall_i(rsp_stall_o));

  always #25 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      finish_test();
    end
  end

  // Count one-cycle strobes mid-cycle, where they stand settled
  always @(negedge clk_sys_i)
  begin
    if (tx_purge_o === 2'b01)
      n_pulse[0]++;
    if (rx_purge_o === 2'b10)
      n_pulse[1]++;
    if (brk_load_o === 2'b01)
      n_pulse[2]++;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rx_char(input int ch, input logic [7:0] c);
    rx_char_i[ch] = c;
    rx_char_valid_i[ch] = 1'b1;
    @(posedge clk_sys_i);
    #1;
    rx_char_valid_i[ch] = 1'b0;
  endtask

  task automatic t_reset;
    host.rd(8'h00, 8'h07, d);
    chk("resume_char", 16'h0011, d);
    host.rd(8'h02, 8'h08, d);
    chk("pause_char", 16'h0013, d);
    chk("read answered", 16'h0001, 16'(host.rsp_ok));
    host.rd(8'h00, 8'h00, d);
    chk("channel_on_switch", 16'h0000, d);
    $display("t_reset done");
  endtask

  task automatic t_enable;
    host.wr(8'h00, 8'h00, 16'h0002);
    chk("rx_en", 16'h0001, 16'(cfg_o[0].rx_en));
    chk("tx_en", 16'h0000, 16'(cfg_o[0].tx_en));
    host.wr(8'h00, 8'h00, 16'h0001);
    host.rd(8'h00, 8'h00, d);
    chk("enable readback", 16'h0001, d);
    chk("other channel", 16'h0000, 16'({cfg_o[1].rx_en, cfg_o[1].tx_en}));
    $display("t_enable done");
  endtask

  task automatic t_flow;
    for (int m = 0; m < 5; m++)
    begin
      host.cfg_write(8'h00, 8'h06, 16'(m), 16'h0003);
      chk("flow_mode", 16'(m), 16'(cfg_o[0].flow_mode));
    end
    host.cfg_write(8'h02, 8'h06, 16'h0002, 16'h0003);
    rx_char(0, 8'h13);
    chk("no pause outside mode 2", 16'h0000, 16'(tx_paused_o[0]));
    rx_char(1, 8'h13);
    chk("paused", 16'h0001, 16'(tx_paused_o[1]));
    rx_char(1, 8'h11);
    chk("resumed", 16'h0000, 16'(tx_paused_o[1]));
    host.cfg_write(8'h00, 8'h06, 16'h0002, 16'h0003);
    rx_char(0, 8'h13);
    chk("paused channel A", 16'h0001, 16'(tx_paused_o[0]));
    host.cfg_write(8'h00, 8'h06, 16'h0008, 16'h0003);
    chk("pause dropped", 16'h0000, 16'(tx_paused_o[0]));
    chk("half_duplex", 16'h0001, 16'(cfg_o[0].half_duplex));
    $display("t_flow done");
  endtask

  task automatic t_fault;
    fault_i[0] = 5'b00100;
    fault_i[1] = 5'b01000;
    @(posedge clk_sys_i);
    #1;
    fault_i = '0;
    host.rd(8'h00, 8'h09, d);
    chk("parity flag", 16'h0020, d);
    host.rd(8'h00, 8'h09, d);
    chk("flags cleared", 16'h0000, d);
    host.rd(8'h02, 8'h09, d);
    chk("overrun flag", 16'h0040, d);
    $display("t_fault done");
  endtask

  task automatic t_unmapped;
    host.rd(8'h00, 8'h05, d);
    chk("unmapped read", 16'h0000, d);
    chk("unmapped answered", 16'h0001, 16'(host.rsp_ok));
    host.cfg_write(8'h00, 8'h05, 16'h00ff, 16'h0003);
    host.rd(8'h00, 8'h05, d);
    chk("unmapped write", 16'h0000, d);
    host.cfg_write(8'h00, 8'h41, 16'h0005, 16'h0003);
    host.rd(8'h00, 8'h41, d);
    chk("tx_queue_level", 16'h0155, d);
    $display("t_unmapped done");
  endtask

  task automatic t_special;
    host.xfer(8'hc0, 16'h0260, 16'h0000, 8'h00, d);
    chk("silicon_version", 16'h0001, d);
    host.rd(8'h00, 8'h60, d);
    chk("general read 0x60", 16'h0000, d);
    host.xfer(8'h40, 16'h0262, 16'h1234, 8'h00, d);
    host.xfer(8'hc0, 16'h0262, 16'h0000, 8'h00, d);
    chk("link status", 16'h1234, d);
    host.rd(8'h02, 8'h62, d);
    chk("general read 0x262", 16'h0000, d);
    host.xfer(8'hc1, 16'h0000, 16'h0000, 8'h01, d);
    chk("bad code stall", 16'h0001, 16'(host.rsp_stall_seen));
    $display("t_special done");
  endtask

  task automatic t_pins;
    host.wr(8'h00, 8'h0e, 16'h0005);
    chk("drive high", 16'h0005, 16'(pin_out_o[0]));
    host.wr(8'h00, 8'h0f, 16'h0001);
    chk("drive low", 16'h0004, 16'(pin_out_o[0]));
    $display("t_pins done");
  endtask

  task automatic t_fields;
    host.cfg_write(8'h00, 8'h40, 16'h0001, 16'h0003);
    host.cfg_write(8'h02, 8'h43, 16'h0003, 16'h0003);
    host.wr(8'h00, 8'h0a, 16'h0100);
    chk("tx purge pulses", 16'h0001, 16'(n_pulse[0]));
    chk("rx purge pulses", 16'h0001, 16'(n_pulse[1]));
    chk("break loads", 16'h0001, 16'(n_pulse[2]));
    chk("break_duration", 16'h0100, cfg_o[0].brk_len);
    host.rd(8'h02, 8'h43, d);
    chk("rx_queue_purge", 16'h0003, d);
    host.cfg_write(8'h00, 8'h0b, 16'h0005, 16'h0003);
    chk("transceiver_delay", 16'h0005, 16'(cfg_o[0].xcvr_delay));
    host.cfg_write(8'h00, 8'h0d, 16'h0201, 16'h0003);
    chk("pin_direction", 16'h0201, 16'(cfg_o[0].pin_dir));
    host.cfg_write(8'h00, 8'h08, 16'h0055, 16'h0003);
    chk("pause_char", 16'h0055, 16'(cfg_o[0].pause_char));
    chk("resume_char", 16'h0011, 16'(cfg_o[0].resume_char));
    host.rd(8'h00, 8'h10, d);
    chk("pin_level", 16'h0155, d);
    host.rd(8'h02, 8'h44, d);
    chk("rx_queue_level", 16'h0003, d);
    $display("t_fields done");
  endtask

  task automatic t_rereset;
    @(posedge clk_sys_i);
    #1;
    reset_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    chk("enable after reset", 16'h0000, 16'({cfg_o[0].rx_en, cfg_o[0].tx_en}));
    chk("pause_char after reset", 16'h0013, 16'(cfg_o[0].pause_char));
    host.rd(8'h00, 8'h06, d);
    chk("flow after reset", 16'h0000, d);
    $display("t_rereset done");
  endtask

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial
  begin
    clk_sys_i = 1'b0;
    reset_i = 1'b1;
    fault_i = '0;
    rx_char_valid_i = '0;
    rx_char_i = '0;
    pin_level_i = {12'h2aa, 12'h155};
    tx_count_i = {10'h0aa, 10'h155};
    rx_count_i = {10'h003, 10'h004};
    failures = 0;
    n_tests = 0;
    cycles = 0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    t_reset();
    t_enable();
    t_flow();
    t_fault();
    t_unmapped();
    t_special();
    t_pins();
    t_fields();
    t_rereset();
    finish_test();
  end
endmodule // tb
